// File: verilog/cpu_flags_unit.sv
// Status flag register, flag generation for executed operations, condition test,
// branch and index address forming, and registered opcode decode.
// Assumes operands arrive with exec_valid and the register file forwards flag writes.
`timescale 1ns/1ps
`include "cpu_flags_defines.svh"
module cpu_flags_unit
  import cpu_flags_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        srst,
  input  wire logic        exec_valid,
  input  wire logic [7:0]  opcode,
  input  wire logic [7:0]  dst_val,
  input  wire logic [7:0]  src_val,
  input  wire logic [7:0]  dst_addr,
  input  wire reg_wr_s     reg_wr,
  input  wire logic [15:0] next_pc,
  input  wire logic [7:0]  disp,
  input  wire logic [7:0]  pair_addr,
  input  wire logic        pair_use,
  input  wire logic [15:0] pair_val,
  input  wire logic        irq_entry,
  input  wire logic        interrupt_return_instr_restore,
  input  wire logic [7:0]  restore_data,
  output logic [7:0]       flags,
  output decode_s          decoded,
  output logic [7:0]       result,
  output logic             result_we,
  output logic             cond_taken,
  output logic [15:0]      target,
  output logic [15:0]      index_addr,
  output logic             pair_fault,
  output logic             undefined,
  output logic [7:0]       stack_byte
);
  state_s  st_q;
  state_s  st_d;
  decode_s dec;

  opcode_decoder u_dec (
    .opcode (opcode),
    .dec    (dec)
  );

  // Condition test: the low three bits pick a term, the top bit inverts it.
  function automatic logic cond_eval(input logic [3:0] code, input logic [7:0] f);
    logic t;
    logic sv;
    t  = 1'b0;
    sv = f[`FLAG_S] ^ f[`FLAG_V];
    unique case (code[2:0])
      3'h0: t = 1'b0;
      3'h1: t = sv;
      3'h2: t = f[`FLAG_Z] | sv;
      3'h3: t = f[`FLAG_C] | f[`FLAG_Z];
      3'h4: t = f[`FLAG_V];
      3'h5: t = f[`FLAG_S];
      3'h6: t = f[`FLAG_Z];
      3'h7: t = f[`FLAG_C];
    endcase
    return t ^ code[3];
  endfunction

  function automatic logic [15:0] sext_add(input logic [15:0] base, input logic [7:0] off);
    return base + {{8{off[7]}}, off};
  endfunction

  always_comb begin
    logic [8:0] sum;
    logic [7:0] r;
    logic [7:0] f;
    logic       cin;
    logic       upd_zs;
    logic       wr;
    sum    = 9'h000;
    r      = 8'h00;
    f      = st_q.flags;
    cin    = st_q.flags[`FLAG_C];
    upd_zs = 1'b0;
    wr     = 1'b0;
    st_d   = st_q;
    st_d.result_we = 1'b0;
    if (reg_wr.en && reg_wr.addr == `FLAGS_ADDR) begin
      f = reg_wr.data;
    end
    if (exec_valid) begin
      st_d.dec       = dec;
      st_d.undefined = !dec.defined;
      unique case (dec.op)
        op_add, op_adc: begin
          sum = {1'b0, dst_val} + {1'b0, src_val} + {8'h00, cin & (dec.op == op_adc)};
          r   = sum[7:0];
          f[`FLAG_C] = sum[8];
          f[`FLAG_V] = (dst_val[7] == src_val[7]) && (r[7] != dst_val[7]);
          upd_zs = 1'b1;
          wr     = 1'b1;
        end
        op_sub, op_sbc, op_cp: begin
          sum = {1'b0, dst_val} - {1'b0, src_val} - {8'h00, cin & (dec.op == op_sbc)};
          r   = sum[7:0];
          f[`FLAG_C] = sum[8];
          f[`FLAG_V] = (dst_val[7] != src_val[7]) && (r[7] != dst_val[7]);
          upd_zs = 1'b1;
          wr     = (dec.op != op_cp);
        end
        op_or, op_and, op_xor, test_complement_mask, test_mask, op_com: begin
          unique case (dec.op)
            op_or:                r = dst_val | src_val;
            op_and, test_mask:    r = dst_val & src_val;
            op_xor:               r = dst_val ^ src_val;
            test_complement_mask: r = ~dst_val & src_val;
            default:              r = ~dst_val;
          endcase
          f[`FLAG_V] = 1'b0;
          upd_zs = 1'b1;
          wr     = (dec.op != test_mask) && (dec.op != test_complement_mask);
        end
        op_inc, op_dec: begin
          r = (dec.op == op_inc) ? dst_val + 8'h01 : dst_val - 8'h01;
          f[`FLAG_V] = (dec.op == op_inc) ? (r == 8'h80) : (r == 8'h7f);
          upd_zs = 1'b1;
          wr     = 1'b1;
        end
        op_rl, rotate_left_through_carry: begin
          r = {dst_val[6:0], (dec.op == op_rl) ? dst_val[7] : cin};
          f[`FLAG_C] = dst_val[7];
          f[`FLAG_V] = r[7] ^ dst_val[7];
          upd_zs = 1'b1;
          wr     = 1'b1;
        end
        op_rr, rotate_right_through_carry, arithmetic_shift_right: begin
          unique case (dec.op)
            op_rr:                      r = {dst_val[0], dst_val[7:1]};
            rotate_right_through_carry: r = {cin, dst_val[7:1]};
            default:                    r = {dst_val[7], dst_val[7:1]};
          endcase
          f[`FLAG_C] = dst_val[0];
          f[`FLAG_V] = (dec.op == arithmetic_shift_right) ? 1'b0 : r[7] ^ dst_val[7];
          upd_zs = 1'b1;
          wr     = 1'b1;
        end
        carry_set_instr:    f[`FLAG_C] = 1'b1;
        carry_reset_instr:  f[`FLAG_C] = 1'b0;
        carry_invert_instr: f[`FLAG_C] = ~st_q.flags[`FLAG_C];
        op_clr: begin
          r  = 8'h00;
          wr = 1'b1;
        end
        op_ld, op_pop: begin
          r  = src_val;
          wr = 1'b1;
        end
        default: begin
          r  = 8'h00;
          wr = 1'b0;
        end
      endcase
      if (upd_zs) begin
        f[`FLAG_S] = r[7];
        f[`FLAG_Z] = (r == 8'h00);
      end
      if (wr && dst_addr == `FLAGS_ADDR) begin
        f = r;
      end
      st_d.result     = r;
      st_d.result_we  = wr;
      st_d.cond_taken = dec.cond_jump && cond_eval(dec.jump_condition_field, st_q.flags);
      st_d.target     = (dec.op == op_jr_cc) ? sext_add(next_pc, disp)
                                             : pair_val & `DA_MASK;
      st_d.index_addr = sext_add(pair_val, disp);
      st_d.pair_fault = pair_use && pair_addr[0];
    end
    if (irq_entry) begin
      st_d.stack_byte = st_q.flags;
    end
    if (interrupt_return_instr_restore) begin
      f = restore_data;
    end
    st_d.flags = f;
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      st_q       <= '0;
      st_q.flags <= `FLAGS_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  assign flags      = st_q.flags;
  assign decoded    = st_q.dec;
  assign result     = st_q.result;
  assign result_we  = st_q.result_we;
  assign cond_taken = st_q.cond_taken;
  assign target     = st_q.target;
  assign index_addr = st_q.index_addr;
  assign pair_fault = st_q.pair_fault;
  assign undefined  = st_q.undefined;
  assign stack_byte = st_q.stack_byte;

  // Helpers for the checks below; the checks gated by quiet watch only single-source cycles.
  logic quiet;
  assign quiet = !interrupt_return_instr_restore && !(reg_wr.en && reg_wr.addr == `FLAGS_ADDR)
                 && dst_addr != `FLAGS_ADDR;

  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  property p_and_flags;
    exec_valid && quiet && dec.op == op_and |=>
      flags[`FLAG_Z] == (($past(dst_val) & $past(src_val)) == 8'h00) && !flags[`FLAG_V];
  endproperty
  a_and_flags: assert property (p_and_flags) else $error("and flags wrong");

  property p_logic_v;
    exec_valid && quiet && (dec.op == op_or || dec.op == op_xor || dec.op == op_com)
      |=> !flags[`FLAG_V];
  endproperty
  a_logic_v: assert property (p_logic_v) else $error("logic op kept overflow");

  property p_add_carry;
    exec_valid && quiet && dec.op == op_add |=>
      flags[`FLAG_C] == ({1'b0, $past(dst_val)} + {1'b0, $past(src_val)} > 9'h0ff);
  endproperty
  a_add_carry: assert property (p_add_carry) else $error("add carry wrong");

  property p_add_ovf;
    exec_valid && quiet && dec.op == op_add && dst_val == 8'h7f && src_val == 8'h01
      |=> flags[`FLAG_V] && flags[`FLAG_S] && !flags[`FLAG_Z];
  endproperty
  a_add_ovf: assert property (p_add_ovf) else $error("overflow not set");

  property p_sign;
    exec_valid && quiet && dec.op != op_nop && st_d.result_we && dec.op != op_ld
      && dec.op != op_pop && dec.op != op_clr |=> flags[`FLAG_S] == result[7];
  endproperty
  a_sign: assert property (p_sign) else $error("sign differs from msb");

  property p_zero;
    exec_valid && quiet && dec.op == op_sub |=> flags[`FLAG_Z] == (result == 8'h00);
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag wrong");

  property p_shift_carry;
    exec_valid && quiet && dec.op == arithmetic_shift_right |=>
      flags[`FLAG_C] == $past(dst_val[0]) && flags[`FLAG_Z] == (result == 8'h00);
  endproperty
  a_shift_carry: assert property (p_shift_carry) else $error("shift carry wrong");

  property p_carry_invert;
    exec_valid && quiet && dec.op == carry_invert_instr |=>
      flags[`FLAG_C] != $past(flags[`FLAG_C]) && flags[6:0] == $past(flags[6:0]);
  endproperty
  a_carry_invert: assert property (p_carry_invert) else $error("carry invert wrong");

  property p_direct_write;
    reg_wr.en && reg_wr.addr == `FLAGS_ADDR && !exec_valid && !interrupt_return_instr_restore
      |=> flags == $past(reg_wr.data) ##1 ($past(exec_valid) || $past(interrupt_return_instr_restore)
      || $past(reg_wr.en) || flags[3:0] == $past(flags[3:0]));
  endproperty
  a_direct_write: assert property (p_direct_write) else $error("flag write lost");

  property p_restore;
    interrupt_return_instr_restore |=> flags == $past(restore_data);
  endproperty
  a_restore: assert property (p_restore) else $error("flags not restored");

  property p_undef;
    exec_valid && quiet && !dec.defined |=> undefined && !result_we
      && flags == $past(flags);
  endproperty
  a_undef: assert property (p_undef) else $error("undefined opcode acted");

  property p_cond;
    exec_valid && opcode == 8'h6b && !flags[`FLAG_Z] |=> !cond_taken;
  endproperty
  a_cond: assert property (p_cond) else $error("zero condition taken wrongly");

  property p_jr_target;
    exec_valid && dec.op == op_jr_cc |=> target == $past(next_pc) + {{8{$past(disp[7])}},
      $past(disp)};
  endproperty
  a_jr_target: assert property (p_jr_target) else $error("relative target wrong");

  property p_load_flags;
    exec_valid && !interrupt_return_instr_restore && dec.op == op_ld && dst_addr == `FLAGS_ADDR
      |=> flags == $past(src_val);
  endproperty
  a_load_flags: assert property (p_load_flags) else $error("load into flags lost");

  property p_collision;
    exec_valid && !interrupt_return_instr_restore && dec.op == op_and && dst_addr == `FLAGS_ADDR
      |=> flags == ($past(dst_val) & $past(src_val));
  endproperty
  a_collision: assert property (p_collision) else $error("collision kept no result");

  property p_rotate_carry;
    exec_valid && quiet && (dec.op == op_rl || dec.op == rotate_left_through_carry) |=>
      flags[`FLAG_C] == $past(dst_val[7]) && flags[`FLAG_Z] == (result == 8'h00);
  endproperty
  a_rotate_carry: assert property (p_rotate_carry) else $error("rotate carry wrong");

  property p_carry_fixed;
    exec_valid && quiet && (dec.op == carry_set_instr || dec.op == carry_reset_instr) |=>
      flags[`FLAG_C] == $past(opcode[4]) && flags[6:0] == $past(flags[6:0]);
  endproperty
  a_carry_fixed: assert property (p_carry_fixed) else $error("carry set wrong");

  property p_pair_fault;
    exec_valid |=> pair_fault == ($past(pair_use) && $past(pair_addr[0]));
  endproperty
  a_pair_fault: assert property (p_pair_fault) else $error("odd pair not flagged");

  property p_index;
    exec_valid |=> index_addr == $past(pair_val) + {{8{$past(disp[7])}}, $past(disp)};
  endproperty
  a_index: assert property (p_index) else $error("index address wrong");

  property p_low_nibble;
    quiet |=> flags[3:0] == $past(flags[3:0]);
  endproperty
  a_low_nibble: assert property (p_low_nibble) else $error("flag storage bits moved");

  property p_cond_const;
    exec_valid && dec.cond_jump && opcode[6:4] == 3'h0 |=> cond_taken == $past(opcode[7]);
  endproperty
  a_cond_const: assert property (p_cond_const) else $error("fixed condition wrong");

  property p_inc_ovf;
    exec_valid && quiet && dec.op == op_inc |=> flags[`FLAG_V] == ($past(dst_val) == 8'h7f);
  endproperty
  a_inc_ovf: assert property (p_inc_ovf) else $error("increment overflow wrong");

  property p_result_pulse;
    result_we && !exec_valid |=> !result_we;
  endproperty
  a_result_pulse: assert property (p_result_pulse) else $error("write request held");

  c_overflow: cover property (exec_valid && dec.op == op_add ##1 flags[`FLAG_V]);
  c_cond_taken: cover property (exec_valid && dec.cond_jump ##1 cond_taken);
  c_irq_round: cover property (irq_entry ##[1:20] interrupt_return_instr_restore);
  c_undefined: cover property (exec_valid && !dec.defined);
endmodule // cpu_flags_unit

// File: include/cpu_flags_defines.svh
// Offsets, flag bit positions, reset values and fixed opcodes of the flag unit.
// Assumes the register file forwards writes to the flag address on its own port.
`ifndef CPU_FLAGS_DEFINES_SVH
`define CPU_FLAGS_DEFINES_SVH
`define FLAGS_ADDR    8'hd5
`define FLAGS_RESET   8'h00
`define FLAG_V        4
`define FLAG_S        5
`define FLAG_Z        6
`define FLAG_C        7
`define OPC_JP_IND    8'h30
`define OPC_PMEM_LD   8'hc3
`define OPC_PMEM_ST   8'hd3
`define OPC_LD_IND_IM 8'hd6
`define DA_MASK       16'h1fff
`endif

// File: include/cpu_flags_pkg.sv
// Types shared by the flag unit and the opcode decoder.
// Assumes cpu_flags_defines.svh is compiled alongside.
package cpu_flags_pkg;
  typedef enum logic [5:0] {
    op_nop, op_add, op_adc, op_sub, op_sbc, op_or, op_and,
    test_complement_mask, test_mask, op_cp, op_xor, op_dec,
    rotate_left_through_carry, op_inc, op_pop, op_com, op_push,
    op_rl, op_clr, rotate_right_through_carry, arithmetic_shift_right,
    op_rr, op_jp_ind, program_memory_load_decrement,
    program_memory_load_increment, op_ld, program_memory_load,
    op_pmem_store, op_call_ind, op_call_dir, carry_set_instr,
    carry_reset_instr, carry_invert_instr, op_jr_cc, op_jp_cc,
    op_idle, op_stop, op_di, op_ei, op_ret, interrupt_return_instr
  } op_e;
  typedef enum logic [3:0] {
    frm_none, frm_ww, frm_wi, frm_rr, frm_ir, frm_ri, frm_reg, frm_ind
  } form_e;
  typedef struct packed {
    op_e         op;
    form_e       form;
    logic        defined;
    logic        cond_jump;
    logic [3:0]  jump_condition_field;
  } decode_s;
  typedef struct packed {
    logic        en;
    logic [7:0]  addr;
    logic [7:0]  data;
  } reg_wr_s;
  typedef struct packed {
    logic [7:0]  flags;
    decode_s     dec;
    logic [7:0]  result;
    logic        result_we;
    logic        cond_taken;
    logic [15:0] target;
    logic [15:0] index_addr;
    logic        pair_fault;
    logic        undefined;
    logic [7:0]  stack_byte;
  } state_s;
endpackage

// File: verilog/opcode_decoder.sv
// First-byte opcode decoder: operation, operand form and condition field.
// Purely combinational; the flag unit registers what it needs.
`timescale 1ns/1ps
`include "cpu_flags_defines.svh"
module opcode_decoder
  import cpu_flags_pkg::*;
(
  input  wire logic [7:0] opcode,
  output decode_s         dec
);
  logic [3:0] hi;
  logic [3:0] lo;
  assign hi = opcode[7:4];
  assign lo = opcode[3:0];

  always_comb begin
    dec = '{op: op_nop, form: frm_none, defined: 1'b1, cond_jump: 1'b0,
            jump_condition_field: hi};
    if (opcode == `OPC_PMEM_LD) begin
      dec.op = program_memory_load;
    end else if (opcode == `OPC_PMEM_ST) begin
      dec.op = op_pmem_store;
    end else if (opcode == `OPC_LD_IND_IM) begin
      dec.op   = op_ld;
      dec.form = frm_ri;
    end else if (opcode == `OPC_JP_IND) begin
      dec.op = op_jp_ind;
    end else if (hi == 4'he && lo >= 4'h2 && lo <= 4'h6) begin
      unique case (lo)
        4'h2:    dec.op = program_memory_load_decrement;
        4'h3:    dec.op = program_memory_load_increment;
        default: dec.op = op_ld;
      endcase
      dec.form = (lo == 4'h4) ? frm_rr : (lo == 4'h5) ? frm_ir : (lo == 4'h6) ? frm_ri : frm_wi;
    end else if (hi == 4'hf && lo >= 4'h4 && lo <= 4'h6) begin
      unique case (lo)
        4'h4:    dec.op = op_call_ind;
        4'h5:    begin dec.op = op_ld; dec.form = frm_ir; end
        default: dec.op = op_call_dir;
      endcase
    end else if (lo >= 4'h2 && lo <= 4'h6) begin
      unique case (lo)
        4'h2:    dec.form = frm_ww;
        4'h3:    dec.form = frm_wi;
        4'h4:    dec.form = frm_rr;
        4'h5:    dec.form = frm_ir;
        default: dec.form = frm_ri;
      endcase
      case (hi)
        4'h0:    dec.op = op_add;
        4'h1:    dec.op = op_adc;
        4'h2:    dec.op = op_sub;
        4'h3:    dec.op = op_sbc;
        4'h4:    dec.op = op_or;
        4'h5:    dec.op = op_and;
        4'h6:    dec.op = test_complement_mask;
        4'h7:    dec.op = test_mask;
        4'ha:    dec.op = op_cp;
        4'hb:    dec.op = op_xor;
        default: dec.defined = 1'b0;
      endcase
    end else if (lo <= 4'h1) begin
      dec.form = lo[0] ? frm_ind : frm_reg;
      case (hi)
        4'h0:    dec.op = op_dec;
        4'h1:    dec.op = rotate_left_through_carry;
        4'h2:    dec.op = op_inc;
        4'h5:    dec.op = op_pop;
        4'h6:    dec.op = op_com;
        4'h7:    dec.op = op_push;
        4'h9:    dec.op = op_rl;
        4'hb:    dec.op = op_clr;
        4'hc:    dec.op = rotate_right_through_carry;
        4'hd:    dec.op = arithmetic_shift_right;
        4'he:    dec.op = op_rr;
        default: dec.defined = 1'b0;
      endcase
    end else if (lo == 4'h7) begin
      dec.op = (hi == 4'ha || hi == 4'he) ? program_memory_load :
               (hi == 4'hb || hi == 4'hf) ? op_pmem_store : op_ld;
      dec.defined = (hi >= 4'h8);
    end else if (lo == 4'hf) begin
      case (hi)
        4'h6:    dec.op = op_idle;
        4'h7:    dec.op = op_stop;
        4'h8:    dec.op = op_di;
        4'h9:    dec.op = op_ei;
        4'ha:    dec.op = op_ret;
        4'hb:    dec.op = interrupt_return_instr;
        4'hc:    dec.op = carry_reset_instr;
        4'hd:    dec.op = carry_set_instr;
        4'he:    dec.op = carry_invert_instr;
        4'hf:    dec.op = op_nop;
        default: dec.defined = 1'b0;
      endcase
    end else begin
      case (lo)
        4'hb:    begin dec.op = op_jr_cc; dec.cond_jump = 1'b1; end
        4'hd:    begin dec.op = op_jp_cc; dec.cond_jump = 1'b1; end
        4'he:    dec.op = op_inc;
        4'ha:    dec.defined = 1'b0;
        default: dec.op = op_ld;
      endcase
    end
    if (!dec.defined) begin
      dec.op = op_nop;
    end
  end
endmodule // opcode_decoder

// File: tb/cpu_flags_unit_tb.sv
// Self-checking bench for the flag unit; a behavioural flag model is compared after each operation driven through run.
// Assumes the package and the defines header are compiled before this file.
`timescale 1ns/1ps
`include "cpu_flags_defines.svh"
`define CHK(got, exp) begin \
  samples_checked++; \
  if ((got) !== (exp)) begin \
    err_total++; \
    $display("mismatch at %0t: got %h expected %h", $time, got, exp); \
  end \
end
module cpu_flags_unit_tb import cpu_flags_pkg::*;;
  logic        clock = 1'b0, srst = 1'b1, exec_valid = 1'b0, pair_use = 1'b0;
  logic        irq_entry = 1'b0, interrupt_return_instr_restore = 1'b0;
  logic [7:0]  opcode = 8'h00, dst_val = 8'h00, src_val = 8'h00, dst_addr = 8'h00;
  logic [7:0]  disp = 8'h00, pair_addr = 8'h00, restore_data = 8'h00;
  logic [15:0] next_pc = 16'h0000, pair_val = 16'h0000;
  reg_wr_s     reg_wr = '0;
  logic [7:0]  flags, result, stack_byte, fm, er;
  decode_s     decoded;
  logic        result_we, cond_taken, pair_fault, undefined, ewe, to_flags = 1'b0;
  logic [15:0] target, index_addr;
  int          err_total = 0, samples_checked = 0, cyc = 0, seed = 8, i;
  localparam logic [3:0] up2 [0:9] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'ha, 4'hb};
  localparam op_e ex2 [0:9] = '{op_add, op_adc, op_sub, op_sbc, op_or, op_and,
    test_complement_mask, test_mask, op_cp, op_xor};
  localparam logic [3:0] up1 [0:8] = '{4'h0, 4'h1, 4'h2, 4'h6, 4'h9, 4'hb, 4'hc, 4'hd, 4'he};
  localparam op_e ex1 [0:8] = '{op_dec, rotate_left_through_carry, op_inc, op_com, op_rl,
    op_clr, rotate_right_through_carry, arithmetic_shift_right, op_rr};
  localparam form_e fx [0:4] = '{frm_ww, frm_wi, frm_rr, frm_ir, frm_ri};
  localparam logic [7:0] dop [0:25] = '{8'h30, 8'hc3, 8'hd3, 8'he2, 8'he3, 8'he4, 8'he5,
    8'he6, 8'hf4, 8'hf5, 8'hf6, 8'hd6, 8'h50, 8'h70, 8'h6f, 8'h7f, 8'h8f, 8'h9f, 8'haf,
    8'hbf, 8'hff, 8'h87, 8'ha7, 8'hb7, 8'h08, 8'h9c};
  localparam op_e dex [0:25] = '{op_jp_ind, program_memory_load, op_pmem_store,
    program_memory_load_decrement, program_memory_load_increment, op_ld, op_ld, op_ld,
    op_call_ind, op_ld, op_call_dir, op_ld, op_pop, op_push, op_idle, op_stop, op_di,
    op_ei, op_ret, interrupt_return_instr, op_nop, op_ld, program_memory_load,
    op_pmem_store, op_ld, op_ld};
  localparam logic [7:0] cop [0:3] = '{8'hcf, 8'hef, 8'hdf, 8'hef};
  localparam logic [7:0] uop [0:4] = '{8'h07, 8'h17, 8'h77, 8'h31, 8'h40};

  cpu_flags_unit u_dut (.clock, .srst, .exec_valid, .opcode, .dst_val, .src_val, .dst_addr,
    .reg_wr, .next_pc, .disp, .pair_addr, .pair_use, .pair_val, .irq_entry, .interrupt_return_instr_restore,
    .restore_data, .flags, .decoded, .result, .result_we, .cond_taken, .target, .index_addr,
    .pair_fault, .undefined, .stack_byte);

  always #5 clock = ~clock;

  task automatic results();
    if (err_total == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  always @(posedge clock) begin
    cyc++;
    if (cyc > 5000) begin
      err_total++;
      results();
    end
  end

  function automatic logic cond(input logic [3:0] code, input logic [7:0] f);
    logic r;
    case (code[2:0])
      3'h0: r = 1'b0;
      3'h1: r = f[5] ^ f[4];
      3'h2: r = f[6] | (f[5] ^ f[4]);
      3'h3: r = f[7] | f[6];
      3'h4: r = f[4];
      3'h5: r = f[5];
      3'h6: r = f[6];
      default: r = f[7];
    endcase
    return r ^ code[3];
  endfunction

  task automatic model(input logic [7:0] op, input logic [7:0] d, input logic [7:0] s);
    logic [8:0] w;
    logic       c, v;
    c = fm[7];
    v = 1'b0;
    ewe = 1'b1;
    if (op[3:0] >= 4'h2) begin
      ewe = !(op[7:4] inside {4'h6, 4'h7, 4'ha});
      case (op[7:4])
        4'h0: w = d + s;
        4'h1: w = d + s + fm[7];
        4'h2, 4'ha: w = d - s;
        4'h3: w = d - s - fm[7];
        4'h4: w = d | s;
        4'h5, 4'h7: w = d & s;
        4'h6: w = ~d & s;
        default: w = d ^ s;
      endcase
      if (op[7:4] inside {4'h0, 4'h1, 4'h2, 4'h3, 4'ha}) begin
        c = w[8];
        v = (op[5] ? d[7] != s[7] : d[7] == s[7]) && (w[7] != d[7]);
      end
    end else begin
      case (op[7:4])
        4'h0: w = d - 8'h01;
        4'h2: w = d + 8'h01;
        4'h1: w = {d[6:0], fm[7]};
        4'h9: w = {d[6:0], d[7]};
        4'hc: w = {fm[7], d[7:1]};
        4'he: w = {d[0], d[7:1]};
        4'hd: w = {d[7], d[7:1]};
        4'h6: w = ~d;
        default: w = 9'h000;
      endcase
      if (op[7:4] inside {4'h1, 4'h9}) c = d[7];
      if (op[7:4] inside {4'hc, 4'hd, 4'he}) c = d[0];
      if (op[7:4] inside {4'h1, 4'h9, 4'hc, 4'he}) v = w[7] ^ d[7];
      if (op[7:4] == 4'h0) v = d == 8'h80;
      if (op[7:4] == 4'h2) v = d == 8'h7f;
    end
    er = w[7:0];
    if (op[7:4] != 4'hb || op[3:0] >= 4'h2) fm = {c, w[7:0] == 8'h00, w[7], v, fm[3:0]};
  endtask

  task automatic exec(input logic [7:0] op, input logic [7:0] d, input logic [7:0] s);
    @(posedge clock);
    exec_valid <= 1'b1;
    opcode <= op;
    dst_val <= d;
    src_val <= s;
    dst_addr <= to_flags ? `FLAGS_ADDR : 8'($random(seed)) & 8'h7f;
    next_pc <= 16'($random(seed));
    disp <= (i % 5 == 0) ? 8'h80 : (i % 5 == 1) ? 8'h7f : 8'($random(seed));
    pair_val <= 16'($random(seed));
    pair_addr <= 8'($random(seed));
    pair_use <= 1'($random(seed));
    @(posedge clock);
    exec_valid <= 1'b0;
    #1;
    `CHK(index_addr, pair_val + {{8{disp[7]}}, disp})
    `CHK(pair_fault, pair_use & pair_addr[0])
  endtask

  task automatic run(input logic [7:0] op);
    logic [7:0] d, s;
    d = (i % 8 == 1) ? 8'h00 : 8'($random(seed));
    s = (i % 4 == 0) ? d : 8'($random(seed));
    model(op, d, s);
    exec(op, d, s);
    `CHK(flags, fm)
    `CHK(result_we, ewe)
    if (ewe) `CHK(result, er)
    `CHK(undefined, 1'b0)
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_wr <= '{en: 1'b1, addr: a, data: d};
    @(posedge clock);
    reg_wr.en <= 1'b0;
    #1;
    if (a == `FLAGS_ADDR) fm = d;
    `CHK(flags, fm)
  endtask

  initial begin
    repeat (16) @(posedge clock);
    srst <= 1'b0;
    #1;
    fm = 8'h00;
    `CHK(flags, 8'h00)
    `CHK(result_we, 1'b0)
    for (i = 0; i < 8; i++) wr((i % 2) ? 8'hd4 : `FLAGS_ADDR, 8'($random(seed)));
    for (i = 0; i < 200; i++) begin
      run({up2[i % 10], 4'(2 + (i / 10) % 5)});
      `CHK(decoded.op, ex2[i % 10])
      `CHK(decoded.form, fx[(i / 10) % 5])
    end
    for (i = 0; i < 72; i++) begin
      run({up1[i % 9], 4'((i / 9) % 2)});
      `CHK(decoded.op, ex1[i % 9])
      `CHK(decoded.form, ((i / 9) % 2) ? frm_ind : frm_reg)
    end
    for (i = 0; i < 4; i++) begin
      exec(cop[i], 8'h00, 8'h00);
      fm[7] = (cop[i] == 8'hef) ? ~fm[7] : (cop[i] == 8'hdf);
      `CHK(flags, fm)
    end
    for (i = 0; i < 26; i++) begin
      exec(dop[i], 8'($random(seed)), 8'($random(seed)));
      `CHK(decoded.op, dex[i])
      `CHK(flags, fm)
    end
    to_flags = 1'b1;
    exec(8'he4, 8'h00, 8'h5a);
    fm = 8'h5a;
    `CHK(flags, fm)
    exec(8'h52, 8'hf0, 8'h3c);
    to_flags = 1'b0;
    wr(`FLAGS_ADDR, fm);
    for (i = 0; i < 5; i++) begin
      exec(uop[i], 8'h01, 8'h02);
      `CHK(undefined, 1'b1)
      `CHK(result_we, 1'b0)
      `CHK(flags, fm)
    end
    for (i = 0; i < 64; i++) begin
      wr(`FLAGS_ADDR, 8'($random(seed)));
      exec({4'(i % 16), (i < 32) ? 4'hb : 4'hd}, 8'h00, 8'h00);
      `CHK(cond_taken, cond(4'(i % 16), fm))
      `CHK(decoded.jump_condition_field, 4'(i % 16))
      if (i < 32) `CHK(target, next_pc + {{8{disp[7]}}, disp})
      else `CHK(target, pair_val & `DA_MASK)
    end
    @(posedge clock);
    irq_entry <= 1'b1;
    @(posedge clock);
    irq_entry <= 1'b0;
    restore_data <= 8'($random(seed));
    interrupt_return_instr_restore <= 1'b1;
    #1;
    `CHK(stack_byte, fm)
    @(posedge clock);
    interrupt_return_instr_restore <= 1'b0;
    #1;
    `CHK(flags, restore_data)
    @(posedge clock);
    srst <= 1'b1;
    @(posedge clock);
    srst <= 1'b0;
    #1;
    `CHK(flags, 8'h00)
    results();
  end
endmodule // cpu_flags_unit_tb
